// ==== design/ddr3_dev_end.sv ====
// Purpose: device end; samples the command pins and tracks banks and power state
// Assumes: ck and data pins pass two flops before use; mem_rst_n acts asynchronously
// Notes:   data beats are taken on each rising ck during a write window
`timescale 1ns/1ps
// Function
// - precharge one bank, or all with A10
// - row for activate, column plus AP
// - A12 picks BL8 or BC4 when enabled
// - load mode stores address op-code
// - bank inputs select the target bank
// - bank inputs choose mode register 0-3
// - sample all pins at rising ck
// - cke low enters matching power state
// - self-refresh exit on synchronised cke level, no ck edge
// - low power states ignore commands; power-down still takes odt
// - decode only when cs_n low
// - command code from four sampled pins
// - ldm high drops the lower byte
// - odt registered turns termination on/off
// - odt ignored when disabled by mode
// - mem_rst_n resets asynchronously both ways
// - udm high drops the upper byte
// - strobes edge-aligned on reads
module ddr3_dev_end #(
	parameter int ROW_W = ddr3_pins_pkg::ROW_W
) (
	input  wire logic                 clk_i,
	input  wire logic                 arst_n_i,
	input  wire logic [15:0]          rdata_i,
	input  wire logic                 rdrive_i,
	output logic [3:0]                cmd_o,
	output logic                      cmd_vld_o,
	output logic [2:0]                bank_o,
	output logic [ROW_W-1:0]          row_o,
	output logic [9:0]                col_o,
	output logic                      auto_pre_o,
	output logic                      chop4_o,
	output logic [7:0]                open_banks_o,
	output ddr3_pins_pkg::pwr_e       pwr_o,
	output logic                      term_on_o,
	output logic [15:0]               wdata_o,
	output logic [1:0]                wbyte_en_o,
	output logic                      wbeat_o,
	output logic [12:0]               mr0_o,
	output logic [12:0]               mr1_o,
	ddr3_link_if.dev                  link
);
	logic        rst_n;
	logic [2:0]  ck_s;
	logic        ck_rise;
	logic [21:0] pin_m;
	logic [21:0] pin_s;
	logic [17:0] dat_m;
	logic [17:0] dat_s;
	logic        cke_m;
	logic        cke_s;
	logic [3:0]  cmd_q;
	logic        vld_q;
	logic [2:0]  bank_q;
	logic [ROW_W-1:0] row_q;
	logic [9:0]  col_q;
	logic        ap_q;
	logic        chop_q;
	logic [7:0]  open_q;
	ddr3_pins_pkg::pwr_e pwr_q;
	logic        term_q;
	logic [15:0] wd_q;
	logic [1:0]  be_q;
	logic        wbeat_q;
	logic        wr_win_q;
	logic [12:0] mr_q [ddr3_pins_pkg::NUM_MR];
	logic [3:0]  code;
	logic [2:0]  ba;
	logic [12:0] a;
	logic        cke;

	// both resets act without the clock
	assign rst_n = arst_n_i & link.mem_rst_n;

	// two-flop synchronisers for ck, command/address and data pins
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ck_s  <= 3'h0;
			pin_m <= 22'h3f_ffff;
			pin_s <= 22'h3f_ffff;
			dat_m <= 18'h0_0000;
			dat_s <= 18'h0_0000;
			cke_m <= 1'b0;
			cke_s <= 1'b0;
		end else begin
			ck_s  <= {ck_s[1:0], link.ck};
			pin_m <= {link.cs_n, link.ras_n, link.cas_n, link.we_n, link.ba, link.addr,
				link.odt, link.cke};
			pin_s <= pin_m;
			dat_m <= {link.udm, link.ldm, link.dq};
			dat_s <= dat_m;
			cke_m <= link.cke;
			cke_s <= cke_m;
		end
	end

	assign ck_rise = ck_s[1] & ~ck_s[2];
	assign code    = pin_s[21:18];
	assign ba      = pin_s[17:15];
	assign a       = pin_s[14:2];
	assign cke     = pin_s[0];

	// command decode and address capture
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q  <= ddr3_pins_pkg::CMD_DESEL;
			vld_q  <= 1'b0;
			bank_q <= 3'h0;
			row_q  <= '0;
			col_q  <= 10'h000;
			ap_q   <= 1'b0;
			chop_q <= 1'b0;
		end else begin
			vld_q <= 1'b0;
			// commands only heard while fully active
			if (ck_rise && pwr_q == ddr3_pins_pkg::PS_ACTIVE && cke && !code[3]) begin
				cmd_q  <= code;
				vld_q  <= 1'b1;
				bank_q <= ba;
				if (code == ddr3_pins_pkg::CMD_ACT) row_q <= a[ROW_W-1:0];
				if (code == ddr3_pins_pkg::CMD_RD || code == ddr3_pins_pkg::CMD_WR) begin
					col_q  <= a[9:0];
					ap_q   <= a[ddr3_pins_pkg::AP_BIT];
					chop_q <= mr_q[0][ddr3_pins_pkg::MR_OTF_BIT]
						& ~a[ddr3_pins_pkg::BC_BIT];
				end
			end
		end
	end

	// open-row tracking per bank
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			open_q <= 8'h00;
		end else if (ck_rise && pwr_q == ddr3_pins_pkg::PS_ACTIVE && cke && !code[3]) begin
			if (code == ddr3_pins_pkg::CMD_ACT) open_q[ba] <= 1'b1;
			else if (code == ddr3_pins_pkg::CMD_PRE) begin
				if (a[ddr3_pins_pkg::AP_BIT]) open_q <= 8'h00;
				else open_q[ba] <= 1'b0;
			end
		end
	end

	// mode registers, written by load mode
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < ddr3_pins_pkg::NUM_MR; i++) mr_q[i] <= ddr3_pins_pkg::MR_RESET;
		end else if (ck_rise && pwr_q == ddr3_pins_pkg::PS_ACTIVE && cke && !code[3]
			&& code == ddr3_pins_pkg::CMD_MRS) begin
			mr_q[ba[1:0]] <= a;
		end
	end

	// power state: cke sampled at ck for entry and pd exit; sr exit on plain cke level
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q <= ddr3_pins_pkg::PS_ACTIVE;
		end else begin
			unique case (pwr_q)
				ddr3_pins_pkg::PS_ACTIVE:
					if (ck_rise && !cke) begin
						if (open_q != 8'h00) pwr_q <= ddr3_pins_pkg::PS_ACT_PD;
						else if (!code[3] && code == ddr3_pins_pkg::CMD_REF)
							pwr_q <= ddr3_pins_pkg::PS_SELF_REF;
						else pwr_q <= ddr3_pins_pkg::PS_PRE_PD;
					end
				ddr3_pins_pkg::PS_PRE_PD, ddr3_pins_pkg::PS_ACT_PD:
					if (ck_rise && cke) pwr_q <= ddr3_pins_pkg::PS_ACTIVE;
				ddr3_pins_pkg::PS_SELF_REF:
					// ck may be stopped here, so no ck edge is needed
					if (cke_s) pwr_q <= ddr3_pins_pkg::PS_ACTIVE;
			endcase
		end
	end

	// termination follows registered odt unless disabled in mode register 1 or in self-refresh
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) term_q <= 1'b0;
		else if (mr_q[1][ddr3_pins_pkg::MR_ODT_OFF_BIT]) term_q <= 1'b0;
		else if (pwr_q == ddr3_pins_pkg::PS_SELF_REF) term_q <= 1'b0;
		else if (ck_rise) term_q <= pin_s[1];
	end

	// write beats, one per ck rise while a write window is open
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wr_win_q <= 1'b0;
			wd_q     <= 16'h0000;
			be_q     <= 2'h0;
			wbeat_q  <= 1'b0;
		end else begin
			wbeat_q <= 1'b0;
			if (vld_q) wr_win_q <= (cmd_q == ddr3_pins_pkg::CMD_WR);
			if (ck_rise && wr_win_q && link.dq_d_oe == 1'b0) begin
				wd_q    <= dat_s[15:0];
				be_q    <= {~dat_s[17], ~dat_s[16]};
				wbeat_q <= 1'b1;
			end
		end
	end

	assign link.dq_d     = rdata_i;
	assign link.dq_d_oe  = rdrive_i;
	assign link.dqs_d    = {2{ck_s[1]}}; // edge-aligned with read data
	assign link.dqs_d_oe = rdrive_i;
	assign cmd_o         = cmd_q;
	assign cmd_vld_o     = vld_q;
	assign bank_o        = bank_q;
	assign row_o         = row_q;
	assign col_o         = col_q;
	assign auto_pre_o    = ap_q;
	assign chop4_o       = chop_q;
	assign open_banks_o  = open_q;
	assign pwr_o         = pwr_q;
	assign term_on_o     = term_q;
	assign wdata_o       = wd_q;
	assign wbyte_en_o    = be_q;
	assign wbeat_o       = wbeat_q;
	assign mr0_o         = mr_q[0];
	assign mr1_o         = mr_q[1];
endmodule : ddr3_dev_end

// ==== design/ddr3_pins_pkg.sv ====
// Purpose: shared constants for the ddr3 x16 command pin link
// Assumes: 40 MHz system clock on both ends, link clock made by the controller
// Notes:   command codes are {cs_n, ras_n, cas_n, we_n}
package ddr3_pins_pkg;
	localparam int          ROW_W       = 13;
	localparam int          BANK_W      = 3;
	localparam int          DQ_W        = 16;
	localparam int          NUM_BANKS   = 8;
	localparam int          NUM_MR      = 4;
	localparam int          AP_BIT      = 10;
	localparam int          BC_BIT      = 12;
	localparam int          CK_HALF     = 4;
	// mode register 1 bit that disables termination (qtoff-like field)
	localparam int          MR_ODT_OFF_BIT = 0;
	// mode register 0 bit that enables on-the-fly burst chop
	localparam int          MR_OTF_BIT  = 1;
	localparam logic [3:0]  CMD_MRS     = 4'h0;
	localparam logic [3:0]  CMD_REF     = 4'h1;
	localparam logic [3:0]  CMD_PRE     = 4'h2;
	localparam logic [3:0]  CMD_ACT     = 4'h3;
	localparam logic [3:0]  CMD_WR      = 4'h4;
	localparam logic [3:0]  CMD_RD      = 4'h5;
	localparam logic [3:0]  CMD_ZQ      = 4'h6;
	localparam logic [3:0]  CMD_NOP     = 4'h7;
	localparam logic [3:0]  CMD_DESEL   = 4'h8;
	localparam logic [12:0] MR_RESET    = 13'h0000;
	typedef enum logic [1:0] {PS_ACTIVE, PS_PRE_PD, PS_ACT_PD, PS_SELF_REF} pwr_e;
endpackage : ddr3_pins_pkg

// ==== design/ddr3_link_if.sv ====
// Purpose: pins between the memory controller and the ddr3 device end
// Assumes: single-ended view of the differential clock and strobes
// Notes:   the bench resolves dq from the two enables
`timescale 1ns/1ps
interface ddr3_link_if;
	logic        ck;
	logic        cke;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic [2:0]  ba;
	logic [12:0] addr;
	logic        odt;
	logic        ldm;
	logic        udm;
	logic        mem_rst_n;
	logic [15:0] dq_c;
	logic        dq_c_oe;
	logic [1:0]  dqs_c;
	logic        dqs_c_oe;
	logic [15:0] dq_d;
	logic        dq_d_oe;
	logic [1:0]  dqs_d;
	logic        dqs_d_oe;
	logic [15:0] dq;
	logic [1:0]  dqs;
	modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, ldm, udm,
		mem_rst_n, dq_c, dq_c_oe, dqs_c, dqs_c_oe, input dq, dqs);
	modport dev (input ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, ldm, udm,
		mem_rst_n, dq, dqs, output dq_d, dq_d_oe, dqs_d, dqs_d_oe);
endinterface : ddr3_link_if

// ==== design/ddr3_ctrl_end.sv ====
// Purpose: controller end; turns one user command into pin activity
// Assumes: link clock divided from clk_i, pins change on its falling half
// Notes:   one command per link clock period, deselect when idle
`timescale 1ns/1ps
module ddr3_ctrl_end (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        req_i,
	input  wire logic [3:0]  cmd_i,
	input  wire logic [2:0]  ba_i,
	input  wire logic [12:0] addr_i,
	input  wire logic        cke_i,
	input  wire logic        odt_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [1:0]  wmask_i,
	input  wire logic        wdrive_i,
	input  wire logic        mem_rst_n_i,
	output logic             ack_o,
	output logic [15:0]      rdata_o,
	ddr3_link_if.ctrl        link
);
	logic [2:0] div_q;
	logic       ck_q;
	logic [3:0] cmd_q;
	logic [2:0] ba_q;
	logic [12:0] addr_q;
	logic       ack_q;
	logic [15:0] rd_q;
	logic [16:0] rd_m;
	logic [16:0] rd_s;

	// link clock divider: ck toggles every CK_HALF system clocks
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_q <= 3'h0;
			ck_q  <= 1'b0;
		end else if (div_q == 3'(ddr3_pins_pkg::CK_HALF - 1)) begin
			div_q <= 3'h0;
			ck_q  <= ~ck_q;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	// launch on the falling half so values sit still across the rising crossing
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cmd_q  <= ddr3_pins_pkg::CMD_DESEL;
			ba_q   <= 3'h0;
			addr_q <= 13'h0000;
			ack_q  <= 1'b0;
		end else begin
			ack_q <= 1'b0;
			if (div_q == 3'(ddr3_pins_pkg::CK_HALF - 1) && ck_q) begin
				if (req_i) begin
					cmd_q  <= cmd_i;
					ba_q   <= ba_i;
					addr_q <= addr_i;
					ack_q  <= 1'b1;
				end else begin
					cmd_q <= ddr3_pins_pkg::CMD_DESEL;
				end
			end
		end
	end

	// dq is a pin: two flops first, with our own drive flag kept in step with it
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_m <= 17'h1_0000;
			rd_s <= 17'h1_0000;
		end else begin
			rd_m <= {link.dq_c_oe, link.dq};
			rd_s <= rd_m;
		end
	end

	// capture dq whenever we are not driving it, so never our own write data
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) rd_q <= 16'h0000;
		else if (rd_s[16] == 1'b0) rd_q <= rd_s[15:0];
	end

	assign link.ck        = ck_q;
	assign link.cs_n      = cmd_q[3];
	assign link.ras_n     = cmd_q[2];
	assign link.cas_n     = cmd_q[1];
	assign link.we_n      = cmd_q[0];
	assign link.ba        = ba_q;
	assign link.addr      = addr_q;
	assign link.cke       = cke_i;
	assign link.odt       = odt_i;
	assign link.ldm       = wmask_i[0];
	assign link.udm       = wmask_i[1];
	assign link.mem_rst_n = mem_rst_n_i;
	assign link.dq_c      = wdata_i;
	assign link.dq_c_oe   = wdrive_i;
	assign link.dqs_c     = {2{~ck_q}}; // centre of data window
	assign link.dqs_c_oe  = wdrive_i;
	assign ack_o          = ack_q;
	assign rdata_o        = rd_q;
endmodule : ddr3_ctrl_end

// ==== testbench/ddr3_x16_command_pin_interface_sva.sv ====
// Purpose: link checks between the two ddr3 pin ends
// Assumes: ck divided from clk_i, four clk per half period
// Notes:   sees only the interface signals
`timescale 1ns/1ps
module ddr3_x16_command_pin_interface_sva (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        ck,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [2:0]  ba,
	input  wire logic [12:0] addr,
	input  wire logic        dq_c_oe,
	input  wire logic        dqs_c_oe,
	input  wire logic [1:0]  dqs_c,
	input  wire logic        dq_d_oe,
	input  wire logic        dqs_d_oe,
	input  wire logic [1:0]  dqs_d
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// pins move only with the ck fall, so they sit still across the rise
	chk_cmd_at_fall:
	assert property ($changed({cs_n, ras_n, cas_n, we_n}) |-> $fell(ck))
		else $error("command pins moved off the ck fall");
	chk_bank_at_fall:
	assert property ($changed({ba, addr}) |-> $fell(ck))
		else $error("bank or address moved off the ck fall");
	// divider gives equal halves of four clk
	chk_ck_high_len:
	assert property ($rose(ck) |-> ck [*4] ##1 !ck) else $error("ck high half wrong");
	chk_ck_low_len:
	assert property ($fell(ck) |-> !ck [*4] ##1 ck) else $error("ck low half wrong");
	// each data drive comes with its strobe, both lanes alike
	chk_rd_strobe:
	assert property (dq_d_oe |-> dqs_d_oe) else $error("read data without strobe");
	chk_wr_strobe:
	assert property (dq_c_oe |-> dqs_c_oe) else $error("write data without strobe");
	chk_rd_lanes:
	assert property (dqs_d_oe |-> dqs_d[0] == dqs_d[1]) else $error("read strobes differ");
	chk_wr_lanes:
	assert property (dqs_c_oe |-> dqs_c[0] == dqs_c[1]) else $error("write strobes differ");
endmodule : ddr3_x16_command_pin_interface_sva

// ==== testbench/ddr3_x16_command_pin_interface_test.sv ====
// Purpose: drives user sides of both ends and checks the device view
// Assumes: controller makes ck; inputs change 1 ns after clk_i rises
// Notes:   released dq shows a toggling pattern, never a held value
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR %0t compare failed", $time); end end
module ddr3_x16_command_pin_interface_test;
	logic clk_i = 1'b0, arst_n_i = 1'b0, req_i = 1'b0, cke_i = 1'b1, odt_i = 1'b0;
	logic wdrive_i = 1'b0, rdrive_i = 1'b0, mem_rst_n_i = 1'b1, ack_o, v;
	logic [3:0] cmd_i = 4'h8, cmd_o;
	logic [2:0] ba_i = 3'h0, bank_o;
	logic [12:0] addr_i = 13'h0000, row_o, mr0_o, mr1_o;
	logic [15:0] wdata_i = 16'h0000, rdata_i = 16'h0000, rdata_o, wdata_o, dq_last = 16'h0000;
	logic [1:0] wmask_i = 2'h0, wbyte_en_o, dqs_last = 2'h0;
	logic [9:0] col_o;
	logic [7:0] open_banks_o;
	logic cmd_vld_o, auto_pre_o, chop4_o, term_on_o, wbeat_o;
	ddr3_pins_pkg::pwr_e pwr_o;
	int err_count = 0, checks_done = 0;
	ddr3_link_if link ();
	always #12.5 clk_i = ~clk_i;
	// undriven wires invert each cycle so a stale value cannot pass
	assign link.dq = link.dq_c_oe ? link.dq_c : link.dq_d_oe ? link.dq_d : ~dq_last;
	assign link.dqs = link.dqs_c_oe ? link.dqs_c : link.dqs_d_oe ? link.dqs_d : ~dqs_last;
	always @(posedge clk_i) {dq_last, dqs_last} <= {link.dq, link.dqs};
	ddr3_ctrl_end i_ddr3_ctrl_end (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i),
		.cmd_i(cmd_i), .ba_i(ba_i), .addr_i(addr_i), .cke_i(cke_i), .odt_i(odt_i),
		.wdata_i(wdata_i), .wmask_i(wmask_i), .wdrive_i(wdrive_i), .mem_rst_n_i(mem_rst_n_i),
		.ack_o(ack_o), .rdata_o(rdata_o), .link(link));
	ddr3_dev_end i_ddr3_dev_end (.clk_i(clk_i), .arst_n_i(arst_n_i), .rdata_i(rdata_i),
		.rdrive_i(rdrive_i), .cmd_o(cmd_o), .cmd_vld_o(cmd_vld_o), .bank_o(bank_o),
		.row_o(row_o), .col_o(col_o), .auto_pre_o(auto_pre_o), .chop4_o(chop4_o),
		.open_banks_o(open_banks_o), .pwr_o(pwr_o), .term_on_o(term_on_o), .wdata_o(wdata_o),
		.wbyte_en_o(wbyte_en_o), .wbeat_o(wbeat_o), .mr0_o(mr0_o), .mr1_o(mr1_o), .link(link));
	ddr3_x16_command_pin_interface_sva i_ddr3_x16_command_pin_interface_sva (.clk_i(clk_i),
		.arst_n_i(arst_n_i), .ck(link.ck), .cs_n(link.cs_n), .ras_n(link.ras_n),
		.cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr),
		.dq_c_oe(link.dq_c_oe), .dqs_c_oe(link.dqs_c_oe), .dqs_c(link.dqs_c),
		.dq_d_oe(link.dq_d_oe), .dqs_d_oe(link.dqs_d_oe), .dqs_d(link.dqs_d));
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : w
	// request held until ack is seen at a falling edge; v tells if the device decoded it
	task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
		output logic vo, input logic k = 1'b1);
		int n;
		w(1);
		{cmd_i, ba_i, addr_i, req_i} = {c, b, a, 1'b1};
		for (n = 0; n < 20 && ack_o !== 1'b1; n++) @(negedge clk_i);
		w(1);
		req_i = 1'b0;
		cke_i = k;
		vo = 1'b0;
		for (n = 0; n < 12 && !vo; n++) begin
			@(negedge clk_i);
			vo = (cmd_vld_o === 1'b1);
		end
		w(1);
	endtask : cmd
	task automatic beat;
		int n;
		for (n = 0; n < 40 && wbeat_o !== 1'b1; n++) @(negedge clk_i);
		@(negedge clk_i);
	endtask : beat
	task summarize;
		$display("mismatches %0d compares %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	// watchdog well past the expected run of about 380 clk
	initial begin
		#60us;
		err_count++;
		summarize();
	end
	// main sequence
	initial begin
		w(12);
		arst_n_i = 1'b1;
		w(4);
		`CHK(link.cs_n, 1'b1);
		cmd(ddr3_pins_pkg::CMD_MRS, 3'h0, 13'h0002, v);
		`CHK(mr0_o, 13'h0002);
		cmd(ddr3_pins_pkg::CMD_MRS, 3'h1, 13'h0010, v);
		`CHK(mr1_o, 13'h0010);
		`CHK(mr0_o, 13'h0002);
		odt_i = 1'b1;
		w(16);
		`CHK(term_on_o, 1'b1);
		cmd(ddr3_pins_pkg::CMD_ACT, 3'h3, 13'h1abc, v);
		`CHK(cmd_o, ddr3_pins_pkg::CMD_ACT);
		`CHK(row_o, 13'h1abc);
		`CHK(bank_o, 3'h3);
		{wdata_i, wmask_i, wdrive_i} = {16'ha55a, 2'b01, 1'b1};
		cmd(ddr3_pins_pkg::CMD_WR, 3'h3, 13'h0523, v);
		`CHK(col_o, 10'h123);
		`CHK(auto_pre_o, 1'b1);
		`CHK(chop4_o, 1'b1);
		beat();
		`CHK(wbyte_en_o, 2'b10);
		`CHK(wdata_o[15:8], 8'ha5);
		w(1);
		wmask_i = 2'b10;
		beat();
		beat();
		`CHK(wbyte_en_o, 2'b01);
		`CHK(wdata_o[7:0], 8'h5a);
		w(1);
		{wdrive_i, rdata_i, rdrive_i} = {1'b0, 16'h3c96, 1'b1};
		cmd(ddr3_pins_pkg::CMD_RD, 3'h3, 13'h1000, v);
		`CHK(chop4_o, 1'b0);
		w(16);
		`CHK(rdata_o, 16'h3c96);
		rdrive_i = 1'b0;
		cmd(ddr3_pins_pkg::CMD_ACT, 3'h5, 13'h0044, v);
		cmd(ddr3_pins_pkg::CMD_PRE, 3'h3, 13'h0000, v);
		`CHK(open_banks_o, 8'h20);
		cke_i = 1'b0;
		w(16);
		`CHK(pwr_o, ddr3_pins_pkg::PS_ACT_PD);
		cmd(ddr3_pins_pkg::CMD_PRE, 3'h5, 13'h0000, v, 1'b0);
		`CHK(v, 1'b0);
		cke_i = 1'b1;
		w(16);
		`CHK(pwr_o, ddr3_pins_pkg::PS_ACTIVE);
		cmd(ddr3_pins_pkg::CMD_PRE, 3'h0, 13'h0400, v);
		`CHK(open_banks_o, 8'h00);
		cmd(ddr3_pins_pkg::CMD_DESEL, 3'h0, 13'h0000, v);
		`CHK(v, 1'b0);
		cke_i = 1'b0;
		w(16);
		`CHK(pwr_o, ddr3_pins_pkg::PS_PRE_PD);
		cke_i = 1'b1;
		w(16);
		cmd(ddr3_pins_pkg::CMD_REF, 3'h0, 13'h0000, v, 1'b0);
		w(16);
		`CHK(pwr_o, ddr3_pins_pkg::PS_SELF_REF);
		cke_i = 1'b1;
		w(16);
		`CHK(pwr_o, ddr3_pins_pkg::PS_ACTIVE);
		cmd(ddr3_pins_pkg::CMD_MRS, 3'h1, 13'h0001, v);
		w(16);
		`CHK(term_on_o, 1'b0);
		mem_rst_n_i = 1'b0;
		w(4);
		`CHK(mr0_o, 13'h0000);
		summarize();
	end
endmodule : ddr3_x16_command_pin_interface_test
